/* File: design/tsx_core.sv */
// instruction decode and execute for table store, test-skip and xor-immediate
// Behaviour
// - low opcode bits choose pointer update mode
// - pointer is 21-bit byte address
// - pointer spans two megabytes
// - pointer bit zero picks low/high byte
// - post-increment: write then pointer plus one
// - pre-increment: pointer plus one then write
// - test-skip discards next instruction when zero
// - test-skip takes one, two or three cycles
// - bank bit picks shared page or selector
// - extended set uses indexed offset addressing
// - xor immediate updates accumulator, sign, zero
`timescale 1ns/1ns
`include "tsx_defines.svh"
module tsx_core (
   clk,
   rst_n,
   instr,
   instr_valid,
   next_is_two_word,
   ext_set_en,
   bank_page_selector,
   index_base,
   file_rd_data,
   table_byte_latch,
   table_byte_pointer,
   file_rd_addr,
   file_rd_indexed,
   holding_wr,
   holding_addr,
   holding_byte_hi,
   holding_data,
   accum,
   flag_neg,
   flag_zero,
   discard_fetch,
   busy
);
   input wire logic clk;
   input wire logic rst_n;
   input wire logic [15:0] instr;
   input wire logic instr_valid; // a new instruction word is offered
   input wire logic next_is_two_word; // word after the current one is two-word
   input wire logic ext_set_en;
   input wire logic [3:0] bank_page_selector;
   input wire logic [11:0] index_base; // base for indexed literal offset
   input wire logic [7:0] file_rd_data; // same-clock register file answer
   input wire logic [7:0] table_byte_latch;
   output logic [`TSX_PTR_W-1:0] table_byte_pointer;
   output logic [11:0] file_rd_addr;
   output logic file_rd_indexed;
   output logic holding_wr;
   output logic [`TSX_PTR_W-1:0] holding_addr;
   output logic holding_byte_hi;
   output logic [7:0] holding_data;
   output logic [7:0] accum;
   output logic flag_neg;
   output logic flag_zero;
   output logic discard_fetch;
   output logic busy;

   // ************************************************************
   // quarter-cycle counter
   // ************************************************************
   logic [1:0] q_reg; // current quarter, 0 = q1
   logic [1:0] q_next;

   // wraps every four clocks; one instruction cycle per wrap
   always_comb begin
      q_next = q_reg + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= 2'h0;
      end else begin
         q_reg <= q_next;
      end
   end

   logic cyc_end; // last quarter of an instruction cycle
   assign cyc_end = (q_reg == `TSX_Q_WRITE);

   // ************************************************************
   // decode
   // ************************************************************
   logic is_tbl; // table store op
   logic is_tst; // test skip op
   logic is_xor; // xor immediate op
   assign is_tbl = instr_valid && (instr[15:2] == `TSX_OP_TBL_HI);
   assign is_tst = instr_valid && (instr[15:9] == `TSX_OP_TST_HI);
   assign is_xor = instr_valid && (instr[15:8] == `TSX_OP_XOR_HI);

   // operand address for the test-skip op
   logic ilo_mode;
   assign ilo_mode = !instr[8] && ext_set_en && (instr[7:0] <= `TSX_ILO_LIMIT);
   always_comb begin
      file_rd_indexed = is_tst && ilo_mode;
      if (ilo_mode) begin
         file_rd_addr = index_base + {4'h0, instr[7:0]};
      end else if (instr[8]) begin
         file_rd_addr = {bank_page_selector, instr[7:0]};
      end else if (instr[7]) begin
         file_rd_addr = {4'hf, instr[7:0]}; // upper half of shared page
      end else begin
         file_rd_addr = {4'h0, instr[7:0]};
      end
   end

   // ************************************************************
   // execution state and datapath
   // ************************************************************
   tsx_pkg::tsx_state_t state_reg, state_next;
   logic [`TSX_PTR_W-1:0] ptr_reg, ptr_next;
   logic [1:0] mode_reg, mode_next; // latched pointer mode
   logic [7:0] acc_reg, acc_next;
   logic neg_reg, neg_next;
   logic zero_reg, zero_next;
   logic hwr_reg, hwr_next; // one-clock holding write strobe
   logic [`TSX_PTR_W-1:0] haddr_reg, haddr_next;
   logic [7:0] hdata_reg, hdata_next;
   logic [7:0] lat_reg, lat_next; // latch sampled in q2
   logic skip_two_reg, skip_two_next; // skipped op is two words

   // pointer arithmetic; wraps inside the two-megabyte range
   logic [`TSX_PTR_W-1:0] ptr_inc, ptr_dec;
   assign ptr_inc = ptr_reg + 21'h000001;
   assign ptr_dec = ptr_reg - 21'h000001;

   // one transition per instruction cycle, decided at q4
   always_comb begin
      state_next = state_reg;
      ptr_next = ptr_reg;
      mode_next = mode_reg;
      acc_next = acc_reg;
      neg_next = neg_reg;
      zero_next = zero_reg;
      hwr_next = 1'b0;
      haddr_next = haddr_reg;
      hdata_next = hdata_reg;
      lat_next = lat_reg;
      skip_two_next = skip_two_reg;
      unique case (state_reg)
         tsx_pkg::TSX_EXEC: begin
            if (cyc_end) begin
               if (is_tbl) begin
                  mode_next = instr[1:0];
                  state_next = tsx_pkg::TSX_TBL2;
               end else if (is_tst && (file_rd_data == 8'h00)) begin
                  skip_two_next = next_is_two_word;
                  state_next = tsx_pkg::TSX_SKIP;
               end else if (is_xor) begin
                  acc_next = acc_reg ^ instr[7:0];
                  neg_next = acc_next[7];
                  zero_next = (acc_next == 8'h00);
               end
            end
         end
         tsx_pkg::TSX_TBL2: begin
            // second cycle: latch read in q2, holding load in q4
            if (q_reg == `TSX_Q_READ) begin
               lat_next = table_byte_latch;
            end
            if (cyc_end) begin
               hwr_next = 1'b1;
               hdata_next = lat_reg;
               unique case (mode_reg)
                  `TSX_MODE_NONE: begin
                     haddr_next = ptr_reg;
                  end
                  `TSX_MODE_POSTINC: begin
                     haddr_next = ptr_reg;
                     ptr_next = ptr_inc;
                  end
                  `TSX_MODE_POSTDEC: begin
                     haddr_next = ptr_reg;
                     ptr_next = ptr_dec;
                  end
                  `TSX_MODE_PREINC: begin
                     haddr_next = ptr_inc;
                     ptr_next = ptr_inc;
                  end
               endcase
               state_next = tsx_pkg::TSX_EXEC;
            end
         end
         tsx_pkg::TSX_SKIP: begin
            // fetched word is thrown away; a nop cycle runs instead
            if (cyc_end) begin
               state_next = skip_two_reg ? tsx_pkg::TSX_SKIP2 : tsx_pkg::TSX_EXEC;
            end
         end
         tsx_pkg::TSX_SKIP2: begin
            if (cyc_end) begin
               state_next = tsx_pkg::TSX_EXEC;
            end
         end
         default: begin
            state_next = tsx_pkg::TSX_EXEC;
         end
      endcase
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= tsx_pkg::TSX_EXEC;
         ptr_reg <= 21'h000000;
         mode_reg <= 2'h0;
         acc_reg <= 8'h00;
         neg_reg <= 1'b0;
         zero_reg <= 1'b0;
         hwr_reg <= 1'b0;
         haddr_reg <= 21'h000000;
         hdata_reg <= 8'h00;
         lat_reg <= 8'h00;
         skip_two_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ptr_reg <= ptr_next;
         mode_reg <= mode_next;
         acc_reg <= acc_next;
         neg_reg <= neg_next;
         zero_reg <= zero_next;
         hwr_reg <= hwr_next;
         haddr_reg <= haddr_next;
         hdata_reg <= hdata_next;
         lat_reg <= lat_next;
         skip_two_reg <= skip_two_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign table_byte_pointer = ptr_reg;
   assign holding_wr = hwr_reg;
   assign holding_addr = haddr_reg;
   assign holding_byte_hi = haddr_reg[0];
   assign holding_data = hdata_reg;
   assign accum = acc_reg;
   assign flag_neg = neg_reg;
   assign flag_zero = zero_reg;
   // fetch stage must drop the word while a skip cycle runs
   assign discard_fetch = (state_reg == tsx_pkg::TSX_SKIP) || (state_reg == tsx_pkg::TSX_SKIP2);
   assign busy = (state_reg != tsx_pkg::TSX_EXEC);
endmodule

/* File: design/tsx_defines.svh */
// constants for the table store, test-skip and xor-immediate decoder
`ifndef TSX_DEFINES_SVH
`define TSX_DEFINES_SVH
`define TSX_OP_TBL_HI 14'h0003
`define TSX_OP_TST_HI 7'h33
`define TSX_OP_XOR_HI 8'h0a
`define TSX_MODE_NONE 2'h0
`define TSX_MODE_POSTINC 2'h1
`define TSX_MODE_POSTDEC 2'h2
`define TSX_MODE_PREINC 2'h3
`define TSX_ILO_LIMIT 8'h5f
`define TSX_PTR_W 21
`define TSX_PTR_SPAN 22'h200000
`define TSX_Q_READ 2'h1
`define TSX_Q_WRITE 2'h3
`endif

/* File: design/tsx_pkg.sv */
// types for the table store, test-skip and xor-immediate decoder
package tsx_pkg;
   // execution states, one-hot
   typedef enum logic [3:0] {
      TSX_EXEC = 4'h1,
      TSX_TBL2 = 4'h2,
      TSX_SKIP = 4'h4,
      TSX_SKIP2 = 4'h8
   } tsx_state_t;
endpackage

/* File: tb/tb.sv */
// self-checking bench for the table store, test-skip and xor decoder
`timescale 1ns/1ns
module tb;
   logic clk, rst_n, instr_valid, next_is_two_word, ext_set_en, file_rd_indexed, holding_wr;
   logic holding_byte_hi, flag_neg, flag_zero, discard_fetch, busy, s_ext, s_two;
   logic got_idx, got_hi; // indexed flag while offered, byte select of the write
   logic [15:0] instr;
   logic [3:0] bank_page_selector, s_bank;
   logic [11:0] index_base, file_rd_addr, zero_addr, s_zero;
   logic [7:0] file_rd_data, table_byte_latch, accum, holding_data, got_data, acc_m;
   logic [20:0] table_byte_pointer, holding_addr, got_addr;
   int miscompares = 0, n_compared = 0, n_disc, n_wr, n_busy;
   // one register reads null, every other one nonzero
   assign file_rd_data = (file_rd_addr === zero_addr) ? 8'h00 : 8'h5a;
   tsx_core i_tsx_core (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one instruction then two watched cycles, so the quarter phase stays aligned
   task automatic run(input logic [15:0] w, input logic [7:0] latch);
      @(posedge clk);
      instr <= w;
      instr_valid <= 1'b1;
      // wrong latch outside its sampling quarter
      table_byte_latch <= ~latch;
      bank_page_selector <= s_bank;
      ext_set_en <= s_ext;
      next_is_two_word <= s_two;
      zero_addr <= s_zero;
      n_disc = 0;
      n_wr = 0;
      n_busy = 0;
      @(posedge clk);
      #1;
      got_idx = file_rd_indexed;
      // second edge ends q4 and takes the decision; watch from it on
      repeat (2) @(posedge clk);
      instr_valid <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i > 0) @(posedge clk);
         // good latch stands only across the q2 sampling edge of the second cycle
         if (i == 1) table_byte_latch <= latch;
         if (i == 2) table_byte_latch <= ~latch;
         #1;
         if (discard_fetch === 1'b1) n_disc++;
         if (busy === 1'b1) n_busy++;
         if (holding_wr === 1'b1) begin
            n_wr++;
            got_addr = holding_addr;
            got_data = holding_data;
            got_hi = holding_byte_hi;
         end
      end
   endtask
   task automatic t_table(input logic [1:0] mode, input logic [7:0] v, input logic [20:0] addr, ptr);
      run({14'h0003, mode}, v);
      chk("writes", 1, n_wr);
      chk("busy", 4, n_busy);
      chk("data", v, got_data);
      chk("addr", addr, got_addr);
      chk("byte hi", addr[0], got_hi);
      chk("ptr", ptr, table_byte_pointer);
   endtask
   task automatic t_skip(input logic [8:0] af, input logic [3:0] b, input logic e, t, input logic [11:0] z, int n);
      s_bank = b;
      s_ext = e;
      s_two = t;
      s_zero = z;
      run({7'h33, af}, 8'h00);
      chk("skipped", n, n_disc);
      chk("indexed", e && !af[8] && (af[7:0] <= 8'h5f), got_idx);
   endtask
   task automatic t_xor(input logic [7:0] k);
      acc_m = acc_m ^ k;
      run({8'h0a, k}, 8'h00);
      chk("accum", acc_m, accum);
      chk("flags", {acc_m[7], acc_m == 8'h00}, {flag_neg, flag_zero});
      chk("busy", 0, n_busy);
   endtask
   task print_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      print_verdict;
   end
   initial begin
      {rst_n, instr, instr_valid, next_is_two_word, ext_set_en, bank_page_selector} = '0;
      {table_byte_latch, zero_addr, s_ext, s_two, s_bank, s_zero, acc_m} = '0;
      index_base = 12'h100;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk("ptr", 0, table_byte_pointer);
      t_xor(8'ha5);
      t_xor(8'ha5);
      t_xor(8'h3c);
      t_table(2'h2, 8'h11, 21'h000000, 21'h1fffff);
      t_table(2'h1, 8'h22, 21'h1fffff, 21'h000000);
      t_table(2'h3, 8'h33, 21'h000001, 21'h000001);
      t_table(2'h0, 8'h44, 21'h000001, 21'h000001);
      t_skip(9'h010, 4'h0, 1'b0, 1'b0, 12'h010, 4);
      t_skip(9'h090, 4'h0, 1'b0, 1'b1, 12'hf90, 8);
      t_skip(9'h122, 4'h5, 1'b0, 1'b0, 12'h522, 4);
      t_skip(9'h122, 4'h5, 1'b0, 1'b0, 12'h022, 0);
      t_skip(9'h05f, 4'h5, 1'b1, 1'b0, 12'h15f, 4);
      t_skip(9'h060, 4'h5, 1'b1, 1'b0, 12'h060, 4);
      t_xor(8'h00);
      print_verdict;
   end
endmodule

/* File: tb/tsx_core_sva.sv */
// checker for the table store, test-skip and xor decoder
`timescale 1ns/1ns
module tsx_core_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] instr,
   input wire logic next_is_two_word,
   input wire logic ext_set_en,
   input wire logic [11:0] index_base,
   input wire logic [7:0] file_rd_data,
   input wire logic [20:0] table_byte_pointer,
   input wire logic [11:0] file_rd_addr,
   input wire logic file_rd_indexed,
   input wire logic holding_wr,
   input wire logic [20:0] holding_addr,
   input wire logic holding_byte_hi,
   input wire logic [7:0] accum,
   input wire logic flag_neg,
   input wire logic flag_zero,
   input wire logic discard_fetch,
   input wire logic busy
);
   // pointer minus written address: 0, +1 or -1 for the four modes
   logic [20:0] gap;
   assign gap = table_byte_pointer - holding_addr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wr; holding_wr |-> $past(busy) ##1 !holding_wr; endproperty
   a_wr: assert property (p_wr) else $error("bad write pulse");
   // written byte is at the old or the new pointer, and its select follows bit zero
   property p_hi; holding_wr |-> holding_byte_hi == holding_addr[0]
      && (holding_addr == table_byte_pointer || holding_addr == $past(table_byte_pointer)); endproperty
   a_hi: assert property (p_hi) else $error("bad byte select");
   property p_mode; holding_wr |-> gap <= 21'h1 || &gap; endproperty
   a_mode: assert property (p_mode) else $error("bad pointer step");
   property p_ptr; $changed(table_byte_pointer) |-> holding_wr; endproperty
   a_ptr: assert property (p_ptr) else $error("pointer moved alone");
   property p_xor; $changed(accum) |-> $past(instr[15:8]) == 8'h0a
      && accum == ($past(accum) ^ $past(instr[7:0])); endproperty
   a_xor: assert property (p_xor) else $error("bad accumulator");
   property p_flag; $changed(accum) |-> flag_neg == accum[7] && flag_zero == (accum == 8'h00); endproperty
   a_flag: assert property (p_flag) else $error("bad flags");
   property p_len; $rose(discard_fetch) |-> discard_fetch[*4] ##1
      (!discard_fetch or discard_fetch[*4] ##1 !discard_fetch); endproperty
   a_len: assert property (p_len) else $error("bad skip length");
   property p_two; $rose(discard_fetch) && $past(next_is_two_word) |-> discard_fetch[*8]; endproperty
   a_two: assert property (p_two) else $error("short two-word skip");
   property p_why; $rose(discard_fetch) |-> $past(instr[15:9]) == 7'h33 && $past(file_rd_data) == 8'h00; endproperty
   a_why: assert property (p_why) else $error("skip without null");
   property p_idx; file_rd_indexed |-> file_rd_addr == index_base + {4'h0, instr[7:0]}
      && ext_set_en && !instr[8] && instr[7:0] <= 8'h5f; endproperty
   a_idx: assert property (p_idx) else $error("bad indexed access");
   c_wr: cover property (holding_wr);
   c_two: cover property ($rose(discard_fetch) && $past(next_is_two_word));
   c_idx: cover property (file_rd_indexed);
endmodule
bind tsx_core tsx_core_sva i_tsx_core_sva (.*);
